// *** rcsr_consts.vh ***
// rcsr_consts.vh: opcode patterns, field positions and q-phase codes for the
// relative call / soft reset execution block; definitions only.
`ifndef RCSR_CONSTS_VH
`define RCSR_CONSTS_VH
`define RCSR_OPC_CALL_PFX    4'hd
`define RCSR_OPC_SOFT_RESET  16'h00ff
`define RCSR_OPC_TBLWT_HI    14'h0003
`define RCSR_PFX_MSB         15
`define RCSR_PFX_LSB         12
`define RCSR_OFS_MSB         10
`define RCSR_Q1              2'h0
`define RCSR_Q2              2'h1
`define RCSR_Q3              2'h2
`define RCSR_Q4              2'h3
`define RCSR_PC_STEP         21'h000002
`define RCSR_PC_RESET        21'h000000
`endif

// *** rcsr_qgen.v ***
// rcsr_qgen.v: four-phase instruction cycle generator.
// assumes one system clock; each phase lasts one clock.
`timescale 1ns/1ps
`include "rcsr_consts.vh"
module rcsr_qgen (
    input  wire       clk_sys_i,
    input  wire       rst_b_i,
    output reg  [1:0] q_o,
    output reg        q4_o
);
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q_o  <= `RCSR_Q1;
            q4_o <= 1'b0;
        end else begin
            q_o  <= q_o + 2'h1;
            q4_o <= (q_o == `RCSR_Q3);
        end
    end
endmodule

// *** rcsr_core.v ***
// rcsr_core.v: execution of relative call and soft reset plus general
// execution notes (port rmw, timer prescaler clear, flush cycles, table write).
// assumes the fetch unit presents a new opcode each cycle and that stack,
// reset sequencer, ports and table-write engine sit outside this block.
`timescale 1ns/1ps
`include "rcsr_consts.vh"
// Function
// RULE1 - port read-modify-write takes operand from pin levels, not output latch
// RULE2 - write-back to timer zero count with d=1 clears its assigned prescaler
// RULE3 - pc change or true condition takes two cycles, second one a no-op
// RULE4 - second word of two-word instruction reached alone executes as no-op
// RULE5 - started table write continues until it ends, not aborted
// RULE6 - relative call: prefix 1101, 11-bit signed n, pc+2+2n, two cycles
// RULE7 - relative call pushes call address plus 2 onto return stack
// RULE8 - call phases: decode, read and push, process, load pc, then idle cycle
// RULE9 - soft reset 0x00ff, one cycle, same state as master clear reset; code keeps tblwt_busy_o and ends the cycle with pc_o at 2
// RULE10 - soft reset starts master clear sequence in q2; q3 and q4 idle; code still advances pc_o from 0 to 2 in q4
module rcsr_core (
    input  wire        clk_sys_i,
    input  wire        rst_b_i,
    input  wire [15:0] opcode_i,
    input  wire        second_word_i,
    input  wire        port_rmw_i,
    input  wire [7:0]  port_pins_i,
    input  wire [7:0]  port_latch_i,
    input  wire        tzc_wr_i,
    input  wire        dest_d_i,
    input  wire        psc_to_tzc_i,
    input  wire        pc_change_i,
    input  wire        cond_true_i,
    input  wire        tblwt_start_i,
    input  wire        tblwt_done_i,
    output reg  [20:0] pc_o,
    output reg  [20:0] return_stack_top_o,
    output reg         stack_push_o,
    output reg         master_clear_reset_o,
    output reg  [7:0]  rmw_operand_o,
    output reg         prescaler_clr_o,
    output reg         flush_o,
    output reg         tblwt_busy_o,
    output reg  [1:0]  q_phase_o
);
    localparam ST_RUN   = 1'b0;
    localparam ST_FLUSH = 1'b1;

    wire [1:0]  q;
    wire        q4;
    reg         state;
    reg  [20:0] call_target;
    reg  [20:0] ret_addr;
    reg         is_call;
    reg         is_rst;
    reg         is_nop;
    reg  [20:0] next_pc;
    wire [20:0] ofs2;

    rcsr_qgen u_qgen (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .q_o       (q),
        .q4_o      (q4)
    );

    // sign extend n and double it
    assign ofs2 = {{9{opcode_i[`RCSR_OFS_MSB]}}, opcode_i[`RCSR_OFS_MSB:0], 1'b0};

    always @* begin
        is_nop  = (state == ST_FLUSH) || second_word_i; // [RULE3] [RULE4]
        is_call = !is_nop && (opcode_i[`RCSR_PFX_MSB:`RCSR_PFX_LSB] == `RCSR_OPC_CALL_PFX); // [RULE6]
        is_rst  = !is_nop && (opcode_i == `RCSR_OPC_SOFT_RESET); // [RULE9]
        next_pc = pc_o + `RCSR_PC_STEP;
    end

    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state                <= ST_RUN;
            pc_o                 <= `RCSR_PC_RESET;
            return_stack_top_o   <= `RCSR_PC_RESET;
            stack_push_o         <= 1'b0;
            master_clear_reset_o <= 1'b0;
            rmw_operand_o        <= 8'h00;
            prescaler_clr_o      <= 1'b0;
            flush_o              <= 1'b0;
            tblwt_busy_o         <= 1'b0;
            q_phase_o            <= `RCSR_Q1;
            call_target          <= `RCSR_PC_RESET;
            ret_addr             <= `RCSR_PC_RESET;
        end else if (master_clear_reset_o) begin
            // software reset clears every output the external clear does, except tblwt_busy_o [RULE9]
            state                <= ST_RUN;
            pc_o                 <= `RCSR_PC_RESET;
            return_stack_top_o   <= `RCSR_PC_RESET;
            stack_push_o         <= 1'b0;
            master_clear_reset_o <= 1'b0;
            rmw_operand_o        <= 8'h00;
            prescaler_clr_o      <= 1'b0;
            flush_o              <= 1'b0;
            // a running table write is not cut short even by soft reset [RULE5]
            tblwt_busy_o         <= tblwt_busy_o && !tblwt_done_i;
            q_phase_o            <= `RCSR_Q1;
        end else begin
            q_phase_o       <= q;
            stack_push_o    <= 1'b0;
            prescaler_clr_o <= 1'b0;
            // pins, not latch: an input pulled low writes back a zero [RULE1]
            if (port_rmw_i && q == `RCSR_Q2)
                rmw_operand_o <= port_pins_i; // [RULE1]
            // q4 is the registered copy of the fourth phase, same edge as q == Q4
            if (tzc_wr_i && dest_d_i && psc_to_tzc_i && !is_nop && q4)
                prescaler_clr_o <= 1'b1; // [RULE2]
            if (tblwt_start_i)
                tblwt_busy_o <= 1'b1; // [RULE5]
            else if (tblwt_done_i)
                tblwt_busy_o <= 1'b0; // [RULE5]
            case (q)
                `RCSR_Q1: begin
                    if (is_call) begin
                        call_target <= next_pc + ofs2; // [RULE6]
                        ret_addr    <= next_pc; // [RULE7]
                    end
                end
                `RCSR_Q2: begin
                    if (is_call) begin
                        stack_push_o       <= 1'b1; // [RULE8]
                        return_stack_top_o <= ret_addr; // [RULE7]
                    end
                    if (is_rst)
                        master_clear_reset_o <= 1'b1; // [RULE10]
                end
                `RCSR_Q3: begin
                end
                `RCSR_Q4: begin
                    if (is_call) begin
                        pc_o    <= call_target; // [RULE8]
                        state   <= ST_FLUSH; // [RULE3]
                        flush_o <= 1'b1;
                    end else if (!is_nop && (pc_change_i || cond_true_i)) begin
                        pc_o    <= next_pc;
                        state   <= ST_FLUSH; // [RULE3]
                        flush_o <= 1'b1;
                    end else begin
                        pc_o    <= next_pc;
                        state   <= ST_RUN;
                        flush_o <= 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
    end
endmodule

// *** rcsr_core_sva.sv ***
// checker for rcsr_core: relative call, soft reset and execution notes
// assumes one clock domain with an asynchronous active-low reset
`timescale 1ns/1ps
module rcsr_core_sva (
    input wire        clk_sys_i,
    input wire        rst_b_i,
    input wire [7:0]  port_pins_i,
    input wire        tzc_wr_i,
    input wire        dest_d_i,
    input wire        psc_to_tzc_i,
    input wire        tblwt_done_i,
    input wire [20:0] pc_o,
    input wire [20:0] return_stack_top_o,
    input wire        stack_push_o,
    input wire        master_clear_reset_o,
    input wire [7:0]  rmw_operand_o,
    input wire        prescaler_clr_o,
    input wire        flush_o,
    input wire        tblwt_busy_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    chk_push_ret: assert property (stack_push_o |-> return_stack_top_o == pc_o + 21'h2) else $error("bad top");
    chk_call_two: assert property (stack_push_o |-> ##[1:5] flush_o) else $error("call lacks flush");
    chk_flush_len: assert property ($rose(flush_o) |-> flush_o [*4] ##1 !flush_o) else $error("flush length");
    chk_flush_nop: assert property (flush_o |-> !stack_push_o) else $error("push in flush");
    chk_soft_clear: assert property (master_clear_reset_o |=> !master_clear_reset_o && pc_o == 21'h0
        && return_stack_top_o == 21'h0) else $error("soft reset state");
    chk_rmw_pins: assert property ($changed(rmw_operand_o) && !master_clear_reset_o
        && !$past(master_clear_reset_o) |-> rmw_operand_o == $past(port_pins_i)) else $error("operand not pins");
    chk_psc_cause: assert property (prescaler_clr_o |-> $past(tzc_wr_i && dest_d_i && psc_to_tzc_i)) else $error("psc");
    chk_tbl_hold: assert property (tblwt_busy_o && !tblwt_done_i |=> tblwt_busy_o) else $error("write aborted");
    cover property (stack_push_o);
    cover property (master_clear_reset_o);
    cover property (prescaler_clr_o);
endmodule
bind rcsr_core rcsr_core_sva rcsr_core_sva_i (.clk_sys_i, .rst_b_i, .port_pins_i, .tzc_wr_i, .dest_d_i,
    .psc_to_tzc_i, .tblwt_done_i, .pc_o, .return_stack_top_o, .stack_push_o, .master_clear_reset_o,
    .rmw_operand_o, .prescaler_clr_o, .flush_o, .tblwt_busy_o);

// *** test_relative_call_and_soft_reset_exec.sv ***
// testbench for rcsr_core: one opcode per four-clock instruction cycle
// assumes cycle boundaries every four clocks from reset release
`timescale 1ns/1ps
module test_relative_call_and_soft_reset_exec;
    reg         clk_sys_i = 1'b0, rst_b_i = 1'b0, second_word_i = 1'b0, port_rmw_i = 1'b0, tzc_wr_i = 1'b0;
    reg         dest_d_i = 1'b0, psc_to_tzc_i = 1'b0, pc_change_i = 1'b0, cond_true_i = 1'b0;
    reg         tblwt_start_i = 1'b0, tblwt_done_i = 1'b0;
    reg  [15:0] opcode_i = 16'h0000;
    reg  [7:0]  port_pins_i = 8'h00, port_latch_i = 8'h00;
    reg  [20:0] seen = 21'h0, n_push = 21'h0, n_mcr = 21'h0, n_psc = 21'h0;
    wire [20:0] pc_o, return_stack_top_o;
    wire [7:0]  rmw_operand_o;
    wire [1:0]  q_phase_o;
    wire        stack_push_o, master_clear_reset_o, prescaler_clr_o, flush_o, tblwt_busy_o;
    integer     err_count = 0, tests_run = 0, cycles = 0;
    rcsr_core rcsr_core_i (.clk_sys_i, .rst_b_i, .opcode_i, .second_word_i, .port_rmw_i, .port_pins_i,
        .port_latch_i, .tzc_wr_i, .dest_d_i, .psc_to_tzc_i, .pc_change_i, .cond_true_i, .tblwt_start_i,
        .tblwt_done_i, .pc_o, .return_stack_top_o, .stack_push_o, .master_clear_reset_o, .rmw_operand_o,
        .prescaler_clr_o, .flush_o, .tblwt_busy_o, .q_phase_o);
    initial begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    // pulse counters let scenarios judge one-clock outputs without racing the edge
    always @(posedge clk_sys_i) begin
        n_push <= n_push + stack_push_o;
        n_mcr <= n_mcr + master_clear_reset_o;
        n_psc <= n_psc + prescaler_clr_o;
        cycles = cycles + 1;
        if (cycles == 400) begin
            err_count = err_count + 1;
            tally_and_finish;
        end
    end
    task check(input [20:0] got, input [20:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // flags: second word, rmw, timer write, d, prescaler assigned, pc change, condition true
    task cyc(input [15:0] op, input [6:0] f);
        begin
            opcode_i <= op;
            {second_word_i, port_rmw_i, tzc_wr_i, dest_d_i, psc_to_tzc_i, pc_change_i, cond_true_i} <= f;
            @(negedge clk_sys_i);
            seen = pc_o;
            repeat (4) @(posedge clk_sys_i);
        end
    endtask
    task t_call(input [10:0] n);
        reg [20:0] p0;
        begin
            rst_b_i <= 1'b0;
            repeat (10) @(posedge clk_sys_i);
            rst_b_i <= 1'b1;
            p0 = n_push;
            cyc(16'h0000, 7'h00);
            check(seen, 21'h0);
            cyc({4'hd, 1'b1, n}, 7'h00);
            check(return_stack_top_o, 21'h4);
            cyc({4'hd, 1'b1, n}, 7'h00);
            check(seen, 21'h4 + {{9{n[10]}}, n, 1'b0});
            check(n_push - p0, 21'h1);
        end
    endtask
    task t_flush;
        reg [20:0] p0;
        begin
            p0 = n_push;
            cyc(16'h0000, 7'h02);
            cyc(16'hd805, 7'h00);
            check(flush_o, 21'h1);
            cyc(16'h0000, 7'h01);
            cyc(16'hd805, 7'h00);
            cyc(16'hd805, 7'h40);
            check(n_push - p0, 21'h0);
        end
    endtask
    task t_rmw_psc;
        begin
            port_pins_i <= 8'h5a;
            port_latch_i <= 8'ha5;
            cyc(16'h0000, 7'h3c);
            check(q_phase_o, 21'h2);
            cyc(16'h0000, 7'h14);
            check(rmw_operand_o, 21'h5a);
            check(n_psc, 21'h1);
        end
    endtask
    task t_soft_reset;
        begin
            tblwt_start_i <= 1'b1;
            cyc(16'h0000, 7'h00);
            tblwt_start_i <= 1'b0;
            cyc(16'h00ff, 7'h00);
            check(n_mcr, 21'h1);
            check(pc_o, 21'h0);
            check(q_phase_o, 21'h0);
            check(return_stack_top_o, 21'h0);
            check(rmw_operand_o, 21'h0);
            check(tblwt_busy_o, 21'h1);
            tblwt_done_i <= 1'b1;
            cyc(16'h0000, 7'h00);
            tblwt_done_i <= 1'b0;
            check(tblwt_busy_o, 21'h0);
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d errors %0d", tests_run, err_count);
            if (err_count == 0 && tests_run > 0) begin
                $display("Result: passed");
            end else begin
                $display("Result: failed");
            end
            $finish;
        end
    endtask
    initial begin
        t_call(11'h3ff);
        t_call(11'h400);
        t_flush;
        t_rmw_psc;
        t_soft_reset;
        tally_and_finish;
    end
endmodule
